// ### src/scc_params.svh
// Constants for the common-command status interpreter
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCC_ESE_RESET 8'h00
`define SCC_SESR_RESET 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCC_SESR_OPC 0
`define SCC_STB_MAV 4
`define SCC_STB_ESB 5

// ----------------------------------------
// Characters and name codes
// ----------------------------------------
`define SCC_CH_LF 8'h0a
`define SCC_CH_SEMI 8'h3b
`define SCC_CH_SPACE 8'h20
`define SCC_CH_ZERO 8'h30
`define SCC_CH_NINE 8'h39
`define SCC_NM_CLS 40'h002a434c53
`define SCC_NM_ESE_W 40'h002a455345
`define SCC_NM_ESE_Q 40'h2a4553453f
`define SCC_NM_ESR_Q 40'h2a4553523f
`define SCC_NM_IDN_Q 40'h2a49444e3f
`define SCC_NM_OPC 40'h002a4f5043

// ----------------------------------------
// Sizes
// ----------------------------------------
`define SCC_NAME_LEN 3'h5
`define SCC_IDN_LEN 5'h16
`define SCC_BUF_LEN 9
`define SCC_ARG_MAX 10'h0ff

`endif

// ### src/scc_pkg.sv
// Types shared by the common-command status interpreter
package scc_pkg;

	typedef enum logic [1:0] {
		ST_NAME = 2'b00,
		ST_ARG = 2'b01,
		ST_EXEC = 2'b10,
		ST_RESP = 2'b11
	} scc_state_t;

	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_CLS = 3'b001,
		CMD_ESE_W = 3'b010,
		CMD_ESE_Q = 3'b011,
		CMD_ESR_Q = 3'b100,
		CMD_IDN_Q = 3'b101,
		CMD_OPC = 3'b110
	} scc_cmd_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} scc_byte_t;

	typedef struct packed {
		logic [7:0] sesr;
		logic [7:0] ese;
		logic [7:0] stb;
	} scc_stat_t;

endpackage

// ### src/scc_dec_fmt.sv
// Byte value to ASCII decimal digits
`timescale 1ns/100ps
`default_nettype none
`include "scc_params.svh"

module scc_dec_fmt (
	// Value
	input wire logic [7:0] value_i,
	// Digits, hundreds first, and how many are significant
	output logic [23:0] digits_o,
	output logic [1:0] ndig_o
);

	logic [7:0] hun;
	logic [7:0] ten;
	logic [7:0] one;

	always_comb begin
		hun = value_i / 8'd100;
		ten = (value_i % 8'd100) / 8'd10;
		one = value_i % 8'd10;
		digits_o = {hun + `SCC_CH_ZERO, ten + `SCC_CH_ZERO, one + `SCC_CH_ZERO};
		if (hun != 8'h00) begin
			ndig_o = 2'h3;
		end else if (ten != 8'h00) begin
			ndig_o = 2'h2;
		end else begin
			ndig_o = 2'h1;
		end
	end

endmodule
`default_nettype wire

// ### src/scc_status_cmds.sv
// Common status command interpreter: clear, event enable, event status, identity
`timescale 1ns/100ps
`default_nettype none
`include "scc_params.svh"

// Functional notes
// - Clear-status zeroes event status register and its summary bit.
// - Clear-status leaves output queue, enable masks and message-available bit alone.
// - Enable write takes one decimal 0..255 into the eight-bit enable mask.
// - Enable mask is zero after power-up reset.
// - Mask bits 7..0 are PON URQ CME EXE DDE QYE RQC OPC.
// - Enable query returns mask in decimal, mask unchanged.
// - Event query returns event register in decimal, then clears it.
// - With headers on, response starts with command name and space.
// - Identity reply: maker, model, serial, version, comma separated.
// - Identity reply never carries a header.
// - Identity query ends a message; nothing more is answered after it.
// - Operation-complete sets event bit 0 once prior actions are done.
// - Event summary bit sits at status byte value 32.
module scc_status_cmds #(
	// Arbitrary identity text, not any real part
	parameter logic [175:0] IDN_STR = "VENDOR,MODEL,SN01,V9.9"
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Command characters in
	input wire scc_pkg::scc_byte_t rx_i,
	output logic rx_ready_o,
	// Response characters out
	output scc_pkg::scc_byte_t tx_o,
	input wire logic tx_ready_i,
	// Instrument side
	input wire logic [7:0] event_set_i,
	input wire logic header_en_i,
	input wire logic mav_i,
	input wire logic op_done_i,
	output scc_pkg::scc_stat_t stat_o
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [7:0] upcase(input logic [7:0] c);
		upcase = ((c >= 8'h61) && (c <= 8'h7a)) ? (c - 8'h20) : c;
	endfunction

	function automatic scc_pkg::scc_cmd_t decode(input logic [39:0] nm);
		if (nm == `SCC_NM_CLS) begin
			decode = scc_pkg::CMD_CLS;
		end else if (nm == `SCC_NM_ESE_W) begin
			decode = scc_pkg::CMD_ESE_W;
		end else if (nm == `SCC_NM_ESE_Q) begin
			decode = scc_pkg::CMD_ESE_Q;
		end else if (nm == `SCC_NM_ESR_Q) begin
			decode = scc_pkg::CMD_ESR_Q;
		end else if (nm == `SCC_NM_IDN_Q) begin
			decode = scc_pkg::CMD_IDN_Q;
		end else if (nm == `SCC_NM_OPC) begin
			decode = scc_pkg::CMD_OPC;
		end else begin
			decode = scc_pkg::CMD_NONE;
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	scc_pkg::scc_state_t state_reg, state_next;
	logic [39:0] name_reg, name_next;
	logic [2:0] nlen_reg, nlen_next;
	logic [9:0] arg_reg, arg_next;
	logic arg_seen_reg, arg_seen_next;
	logic term_lf_reg, term_lf_next;
	logic idn_done_reg, idn_done_next;
	logic resp_idn_reg, resp_idn_next;
	logic [4:0] idx_reg, idx_next;
	logic [4:0] len_reg, len_next;
	logic [7:0] buf_reg [0:`SCC_BUF_LEN-1];
	logic [7:0] buf_next [0:`SCC_BUF_LEN-1];
	scc_pkg::scc_byte_t tx_reg, tx_next;
	logic rx_ready_reg, rx_ready_next;

	logic [7:0] sesr_reg, sesr_next;
	logic [7:0] ese_reg, ese_next;
	logic opc_pend_reg, opc_pend_next;
	logic [7:0] stb_reg, stb_next;

	logic sesr_clr;
	logic opc_req;
	logic [7:0] fmt_val;
	logic [23:0] fmt_dig;
	logic [1:0] fmt_nd;
	logic [7:0] c_up;
	logic [7:0] cur_byte;
	scc_pkg::scc_cmd_t cmd;
	logic ese_next_w;

	scc_dec_fmt u_fmt (
		.value_i(fmt_val),
		.digits_o(fmt_dig),
		.ndig_o(fmt_nd)
	);

	// ----------------------------------------
	// Parser and response sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		name_next = name_reg;
		nlen_next = nlen_reg;
		arg_next = arg_reg;
		arg_seen_next = arg_seen_reg;
		term_lf_next = term_lf_reg;
		idn_done_next = idn_done_reg;
		resp_idn_next = resp_idn_reg;
		idx_next = idx_reg;
		len_next = len_reg;
		buf_next = buf_reg;
		tx_next = tx_reg;
		sesr_clr = 1'b0;
		opc_req = 1'b0;
		c_up = upcase(rx_i.data);
		cmd = decode(name_reg);
		fmt_val = (cmd == scc_pkg::CMD_ESR_Q) ? sesr_reg : ese_reg;
		cur_byte = resp_idn_reg ?
			((idx_reg < `SCC_IDN_LEN) ? IDN_STR[8*(`SCC_IDN_LEN-5'h01-idx_reg) +: 8] : `SCC_CH_LF) :
			buf_reg[idx_reg[3:0]];
		case (state_reg)
			scc_pkg::ST_NAME: begin
				// A byte counts only when the ready flag was shown to the sender
				if (rx_i.valid && rx_ready_reg) begin
					if ((c_up == `SCC_CH_SEMI) || (c_up == `SCC_CH_LF)) begin
						term_lf_next = (c_up == `SCC_CH_LF);
						state_next = scc_pkg::ST_EXEC;
					end else if (c_up == `SCC_CH_SPACE) begin
						if (nlen_reg != 3'h0) begin
							state_next = scc_pkg::ST_ARG;
						end
					end else if (nlen_reg < `SCC_NAME_LEN) begin
						name_next = {name_reg[31:0], c_up};
						nlen_next = nlen_reg + 3'h1;
					end else begin
						// Too long for any known name: poison it
						name_next = 40'h0;
						nlen_next = `SCC_NAME_LEN;
					end
				end
			end
			scc_pkg::ST_ARG: begin
				if (rx_i.valid && rx_ready_reg) begin
					if ((c_up == `SCC_CH_SEMI) || (c_up == `SCC_CH_LF)) begin
						term_lf_next = (c_up == `SCC_CH_LF);
						state_next = scc_pkg::ST_EXEC;
					end else if ((c_up >= `SCC_CH_ZERO) && (c_up <= `SCC_CH_NINE)) begin
						arg_seen_next = 1'b1;
						// Saturate above 255 so a long number cannot wrap back into range
						if (arg_reg > (`SCC_ARG_MAX / 10'd10)) begin
							arg_next = `SCC_ARG_MAX + 10'h1;
						end else begin
							arg_next = 10'(arg_reg * 10'd10 + 10'(c_up - `SCC_CH_ZERO));
						end
					end
				end
			end
			scc_pkg::ST_EXEC: begin
				state_next = scc_pkg::ST_NAME;
				name_next = 40'h0;
				nlen_next = 3'h0;
				arg_next = 10'h0;
				arg_seen_next = 1'b0;
				idx_next = 5'h0;
				// Queries after identity stay silent until message end
				idn_done_next = term_lf_reg ? 1'b0 : idn_done_reg;
				case (cmd)
					scc_pkg::CMD_CLS: begin
						sesr_clr = 1'b1;
					end
					scc_pkg::CMD_ESE_W: begin
						// Mask store lives in the status group
					end
					scc_pkg::CMD_ESE_Q, scc_pkg::CMD_ESR_Q: begin
						if (!idn_done_reg) begin
							sesr_clr = (cmd == scc_pkg::CMD_ESR_Q);
							resp_idn_next = 1'b0;
							len_next = 5'h0;
							if (header_en_i) begin
								for (int i = 0; i < 4; i++) begin
									buf_next[i] = name_reg[39-8*i -: 8];
								end
								buf_next[4] = `SCC_CH_SPACE;
								len_next = 5'h5;
							end
							if (fmt_nd == 2'h3) begin
								buf_next[len_next[3:0]] = fmt_dig[23:16];
								len_next = len_next + 5'h1;
							end
							if (fmt_nd != 2'h1) begin
								buf_next[len_next[3:0]] = fmt_dig[15:8];
								len_next = len_next + 5'h1;
							end
							buf_next[len_next[3:0]] = fmt_dig[7:0];
							buf_next[len_next[3:0] + 4'h1] = `SCC_CH_LF;
							len_next = len_next + 5'h2;
							state_next = scc_pkg::ST_RESP;
						end
					end
					scc_pkg::CMD_IDN_Q: begin
						if (!idn_done_reg) begin
							resp_idn_next = 1'b1;
							len_next = `SCC_IDN_LEN + 5'h1;
							state_next = scc_pkg::ST_RESP;
							idn_done_next = ~term_lf_reg;
						end
					end
					scc_pkg::CMD_OPC: begin
						opc_req = 1'b1;
					end
					default: begin
					end
				endcase
			end
			scc_pkg::ST_RESP: begin
				if (!tx_reg.valid || tx_ready_i) begin
					if (idx_reg < len_reg) begin
						tx_next.valid = 1'b1;
						tx_next.data = cur_byte;
						idx_next = idx_reg + 5'h1;
					end else begin
						tx_next.valid = 1'b0;
						state_next = scc_pkg::ST_NAME;
					end
				end
			end
			default: begin
				state_next = scc_pkg::ST_NAME;
			end
		endcase
		rx_ready_next = (state_next == scc_pkg::ST_NAME) || (state_next == scc_pkg::ST_ARG);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= scc_pkg::ST_NAME;
			name_reg <= 40'h0;
			nlen_reg <= 3'h0;
			arg_reg <= 10'h0;
			arg_seen_reg <= 1'b0;
			term_lf_reg <= 1'b0;
			idn_done_reg <= 1'b0;
			resp_idn_reg <= 1'b0;
			idx_reg <= 5'h0;
			len_reg <= 5'h0;
			for (int i = 0; i < `SCC_BUF_LEN; i++) begin
				buf_reg[i] <= 8'h00;
			end
			tx_reg <= '0;
			rx_ready_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			name_reg <= name_next;
			nlen_reg <= nlen_next;
			arg_reg <= arg_next;
			arg_seen_reg <= arg_seen_next;
			term_lf_reg <= term_lf_next;
			idn_done_reg <= idn_done_next;
			resp_idn_reg <= resp_idn_next;
			idx_reg <= idx_next;
			len_reg <= len_next;
			buf_reg <= buf_next;
			tx_reg <= tx_next;
			rx_ready_reg <= rx_ready_next;
		end
	end

	// ----------------------------------------
	// Status registers
	// ----------------------------------------
	always_comb begin
		ese_next_w = (state_reg == scc_pkg::ST_EXEC) && (cmd == scc_pkg::CMD_ESE_W) &&
			arg_seen_reg && (arg_reg <= `SCC_ARG_MAX);
		// Only the write command touches the mask
		ese_next = ese_next_w ? arg_reg[7:0] : ese_reg;
		// Complete once prior actions report done
		opc_pend_next = opc_req | (opc_pend_reg & ~op_done_i);
		// Hardware events win over a same-cycle clear
		sesr_next = (sesr_clr ? 8'h00 : sesr_reg) | event_set_i;
		sesr_next[`SCC_SESR_OPC] = sesr_next[`SCC_SESR_OPC] | (opc_pend_reg & op_done_i);
		stb_next = 8'h00;
		stb_next[`SCC_STB_MAV] = mav_i;
		stb_next[`SCC_STB_ESB] = |(sesr_next & ese_next);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ese_reg <= `SCC_ESE_RESET;
			sesr_reg <= `SCC_SESR_RESET;
			opc_pend_reg <= 1'b0;
			stb_reg <= 8'h00;
		end else begin
			ese_reg <= ese_next;
			sesr_reg <= sesr_next;
			opc_pend_reg <= opc_pend_next;
			stb_reg <= stb_next;
		end
	end

	assign rx_ready_o = rx_ready_reg;
	assign tx_o = tx_reg;
	// Mask bits map one to one onto event bits
	assign stat_o = '{sesr: sesr_reg, ese: ese_reg, stb: stb_reg};

endmodule
`default_nettype wire

// ### verif/scc_status_cmds_chk.sv
// Assertion checker for the common-command status interpreter
`timescale 1ns/100ps
`default_nettype none
module scc_status_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Watched ports
	input wire scc_pkg::scc_byte_t rx_i,
	input wire logic rx_ready_o,
	input wire scc_pkg::scc_byte_t tx_o,
	input wire logic tx_ready_i,
	input wire logic [7:0] event_set_i,
	input wire logic header_en_i,
	input wire logic mav_i,
	input wire logic op_done_i,
	input wire scc_pkg::scc_stat_t stat_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_stall;
		tx_o.valid && !tx_ready_i;
	endsequence
	sequence s_kept;
		tx_o.valid && $stable(tx_o.data);
	endsequence
	a_tx_hold: assert property (s_stall |=> s_kept)
		else $error("response byte changed before accept");
	a_resp_busy: assert property (tx_o.valid |-> !rx_ready_o)
		else $error("input taken during response");
	a_mav_copy: assert property (1'b1 |=> stat_o.stb[4] == $past(mav_i))
		else $error("message-available bit not copied");
	a_esb_sum: assert property (stat_o.stb[5] == |(stat_o.sesr & stat_o.ese))
		else $error("summary bit wrong");
	a_stb_zero: assert property ((stat_o.stb & 8'hcf) == 8'h00)
		else $error("unused status byte bit set");
	a_evt_set: assert property (|event_set_i |=>
		(stat_o.sesr & $past(event_set_i)) == $past(event_set_i))
		else $error("event bit not set");
	a_sesr_clr: assert property (|($past(stat_o.sesr) & ~stat_o.sesr) |->
		!$past(rx_ready_o))
		else $error("event register cleared outside a command");
	a_ese_write: assert property (stat_o.ese != $past(stat_o.ese) |-> !$past(rx_ready_o))
		else $error("enable mask changed outside a command");
	a_opc_set: assert property ($rose(stat_o.sesr[0]) |->
		$past(op_done_i) || $past(event_set_i[0]))
		else $error("completion bit set early");
	a_ese_reset: assert property ($fell(rst_i) |-> stat_o.ese == 8'h00)
		else $error("enable mask not zero after reset");
endmodule
bind scc_status_cmds scc_status_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .rx_i(rx_i),
	.rx_ready_o(rx_ready_o), .tx_o(tx_o), .tx_ready_i(tx_ready_i), .event_set_i(event_set_i),
	.header_en_i(header_en_i), .mav_i(mav_i), .op_done_i(op_done_i), .stat_o(stat_o));
`default_nettype wire

// ### verif/scc_host_model.sv
// Remote controller model: sends command text, gathers response bytes
`timescale 1ns/100ps
`default_nettype none
module scc_host_model (
	// Clock
	input wire logic clk_i,
	// Command side
	output var scc_pkg::scc_byte_t rx_o,
	input wire logic rx_ready_i,
	// Response side
	input wire scc_pkg::scc_byte_t tx_i,
	output logic tx_ready_o
);
	logic [7:0] rq[$];
	bit slow = 1'b0;
	initial begin
		rx_o = '0;
		tx_ready_o = 1'b0;
	end
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			rx_o.valid = 1'b1;
			rx_o.data = s[i];
			do @(posedge clk_i); while (rx_ready_i !== 1'b1);
			#1;
		end
		rx_o.valid = 1'b0;
		// Released line must not look like a held byte
		rx_o.data = ~rx_o.data;
		@(posedge clk_i);
		#1;
	endtask
	always @(posedge clk_i) begin
		if (tx_i.valid && tx_ready_o)
			rq.push_back(tx_i.data);
		tx_ready_o <= #1 !slow || ($urandom % 3 == 0);
	end
endmodule
`default_nettype wire

// ### verif/test_scc_status_cmds.sv
// Self-checking bench for the common-command status interpreter
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin n_fail++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module test_scc_status_cmds;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] event_set_i = 8'h00;
	logic header_en_i = 1'b0;
	logic mav_i = 1'b0;
	logic op_done_i = 1'b0;
	logic rx_ready_o;
	logic tx_ready_i;
	scc_pkg::scc_byte_t rx_i;
	scc_pkg::scc_byte_t tx_o;
	scc_pkg::scc_stat_t stat_o;
	int n_fail = 0;
	int n_tests = 0;
	int ese = 0;
	int sesr = 0;
	int v;
	scc_status_cmds uut (.clk_i(clk_i), .rst_i(rst_i), .rx_i(rx_i), .rx_ready_o(rx_ready_o),
		.tx_o(tx_o), .tx_ready_i(tx_ready_i), .event_set_i(event_set_i),
		.header_en_i(header_en_i), .mav_i(mav_i), .op_done_i(op_done_i), .stat_o(stat_o));
	scc_host_model host (.clk_i(clk_i), .rx_o(rx_i), .rx_ready_i(rx_ready_o), .tx_i(tx_o),
		.tx_ready_o(tx_ready_i));
	initial forever #2 clk_i = ~clk_i;
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic expect_resp(input string s);
		int k;
		logic [7:0] b;
		for (int i = 0; i < s.len(); i++) begin
			k = 0;
			while (host.rq.size() == 0 && k < 400) begin
				@(posedge clk_i);
				k++;
			end
			b = (host.rq.size() > 0) ? host.rq.pop_front() : 8'hxx;
			`CHK("response byte", 8'(s[i]), b)
		end
		#1;
	endtask
	task automatic query(input string nm, input int val);
		host.send({nm, "?\n"});
		expect_resp({header_en_i ? {nm, " "} : "", $sformatf("%0d\n", val)});
	endtask
	initial begin
		#60000;
		n_fail++;
		test_done;
	end
	initial begin
		v = $urandom(16245);
		wait_n(2);
		rst_i = 1'b0;
		wait_n(1);
		`CHK("mask after reset", 8'h00, stat_o.ese)
		host.slow = 1'b1;
		for (int i = 0; i < 12; i++) begin
			v = (i == 0) ? 36 : (i == 1) ? 255 : (i == 2) ? 0 : $urandom % 256;
			host.send({i[0] ? "*ese " : "*ESE ", $sformatf("%0d\n", v)});
			ese = v;
			wait_n(4);
			`CHK("mask write", 8'(ese), stat_o.ese)
			if (i == 0) `CHK("cme and qye", 8'h24, stat_o.ese)
			header_en_i = i[1];
			query("*ESE", ese);
			`CHK("mask kept", 8'(ese), stat_o.ese)
		end
		host.send("*ESE 256\n");
		wait_n(4);
		`CHK("mask refuses 256", 8'(ese), stat_o.ese)
		host.send("*ESE 1030\n");
		wait_n(4);
		`CHK("mask refuses 1030", 8'(ese), stat_o.ese)
		for (int i = 0; i < 6; i++) begin
			v = $urandom % 256;
			event_set_i = 8'(v);
			wait_n(1);
			event_set_i = 8'h00;
			sesr = sesr | v;
			mav_i = i[0];
			wait_n(2);
			`CHK("event reg", 8'(sesr), stat_o.sesr)
			`CHK("summary bit", 1'((sesr & ese) != 0), stat_o.stb[5])
			if (i[1]) begin
				host.send("*CLS\n");
				wait_n(4);
				`CHK("status after clear", {3'h0, mav_i, 4'h0}, stat_o.stb)
				`CHK("mask after clear", 8'(ese), stat_o.ese)
			end else begin
				query("*ESR", sesr);
			end
			sesr = 0;
			wait_n(2);
			`CHK("event reg cleared", 8'h00, stat_o.sesr)
		end
		host.send("*opc\n");
		wait_n(6);
		`CHK("completion waits", 1'b0, stat_o.sesr[0])
		op_done_i = 1'b1;
		wait_n(2);
		`CHK("completion set", 1'b1, stat_o.sesr[0])
		op_done_i = 1'b0;
		header_en_i = 1'b1;
		host.send("*IDN?;*ESE?\n");
		expect_resp("VENDOR,MODEL,SN01,V9.9\n");
		wait_n(40);
		`CHK("silent after identity", 0, host.rq.size())
		query("*ESR", 1);
		test_done;
	end
endmodule
`default_nettype wire
